// File: core/prl_defs.svh
/*
 * Offsets, field positions, reset values and remap codes of the
 * port-three remap and status/command registers.
 * Assumes an 8-bit register address space on the serial slave side.
 */
`ifndef PRL_DEFS_SVH
`define PRL_DEFS_SVH

// ==========================================================
// register offsets
`define PRL_ADDR_REMAP3    8'hFC
`define PRL_ADDR_STATUS    8'hFF

// ==========================================================
// reset values
`define PRL_REMAP3_RST     4'h3
`define PRL_STATUS_RST     8'h00

// ==========================================================
// status/command fields
`define PRL_STAT_PROT_BIT  0
`define PRL_STAT_SRST_BIT  1

// ==========================================================
// remap nibble codes
`define PRL_CODE_DISABLED  4'h0
`define PRL_CODE_LOG1      4'h1
`define PRL_CODE_LOG3      4'h3
`define PRL_NATURAL_PORT   2'h3

`endif

// File: core/prl_map_if.sv
/*
 * Carrier between the register bank and the remap decoder.
 * Assumes both ends run on the same clock; signals are combinational.
 */
interface prl_map_if;
  logic [3:0] code;
  logic       remap_en;
  logic [1:0] logical;
  logic       enabled;

  modport dec
  (
    input  code,
    input  remap_en,
    output logical,
    output enabled
  );

  modport bank
  (
    output code,
    output remap_en,
    input  logical,
    input  enabled
  );
endinterface : prl_map_if

// File: core/prl_pkg.sv
/*
 * Types shared by the port remap and configuration lock block.
 * Assumes prl_defs.svh for widths of stored fields.
 */
package prl_pkg;

  // ==========================================================
  // register state of the top module
  typedef struct packed {
    logic [3:0] remap;
    logic       protect;
    logic       soft_rst;
    logic [7:0] rdata;
    logic [1:0] port3_log;
    logic       port3_en;
  } prl_state_t;

endpackage : prl_pkg

// File: core/prl_remap_decode.sv
/*
 * Decodes the stored port-three remap code into a logical port number.
 * Assumes the stored code never holds a reserved value.
 */
`include "prl_defs.svh"

module prl_remap_decode
  import prl_pkg::*;
(
  prl_map_if.dec m
);

  // ==========================================================
  // code to logical number
  always_comb
  begin
    if (!m.remap_en)
    begin
      // natural numbering while remap mode is off
      m.enabled = 1'b1;
      m.logical = `PRL_NATURAL_PORT;
    end
    else if (m.code >= `PRL_CODE_LOG1 && m.code <= `PRL_CODE_LOG3)
    begin
      m.enabled = 1'b1;
      m.logical = m.code[1:0];
    end
    else
    begin
      m.enabled = 1'b0;
      m.logical = 2'h0;
    end
  end

endmodule : prl_remap_decode

// File: core/prl_top.sv
/*
 * Port-three remap register and status/command register with soft
 * reset and write-once configuration protect.
 * Assumes a serial slave front end that presents single-cycle byte
 * read and write strobes with an 8-bit register address.
 */
`include "prl_defs.svh"

// Functional notes
// - low nibble picks logical number of port three; zero disables it.
// - codes one to three map port three to logical one to three.
// - reserved codes four and above are stored as the disabled code.
// - remap register resets to 0x03, port three as logical three.
// - remapping applies only while remap mode enable is set.
// - writing one to status bit 1 resets serial side and config.
// - soft reset bit clears itself; zero means normal running.
// - status bit 0 set write-protects configuration memory.
// - protect bit is write once, cleared only by external reset.
// - with protect clear, register accesses are accepted normally.
module prl_top
  import prl_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       remap_mode_enable_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [1:0] port3_logical_o,
  output logic            port3_enable_o,
  output logic            cfg_protect_o,
  output logic            soft_reset_o
);

  prl_state_t state;
  prl_state_t next_state;
  prl_map_if  map ();

  logic wr_remap;
  logic wr_status;

  // ==========================================================
  // decoder
  assign map.code     = state.remap;
  assign map.remap_en = remap_mode_enable_i;

  prl_remap_decode u_dec
  (
    .m (map.dec)
  );

  assign wr_remap  = reg_wr_i && reg_addr_i == `PRL_ADDR_REMAP3;
  assign wr_status = reg_wr_i && reg_addr_i == `PRL_ADDR_STATUS;

  // ==========================================================
  // next state
  always_comb
  begin
    next_state          = state;
    next_state.soft_rst = 1'b0;
    next_state.rdata    = 8'h00;
    if (wr_remap && !state.protect)
    begin
      if (reg_wdata_i[3:0] > `PRL_CODE_LOG3)
        next_state.remap = `PRL_CODE_DISABLED;
      else
        next_state.remap = reg_wdata_i[3:0];
    end
    if (wr_status)
    begin
      if (reg_wdata_i[`PRL_STAT_PROT_BIT])
        next_state.protect = 1'b1;
      if (reg_wdata_i[`PRL_STAT_SRST_BIT])
      begin
        next_state.soft_rst = 1'b1;
        next_state.remap    = `PRL_REMAP3_RST;
      end
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PRL_ADDR_REMAP3: next_state.rdata = {4'h0, state.remap};
        `PRL_ADDR_STATUS: next_state.rdata = {6'h00, state.soft_rst,
                                              state.protect};
        default:          next_state.rdata = 8'h00;
      endcase
    end
    next_state.port3_log = map.logical;
    next_state.port3_en  = map.enabled;
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state.remap     <= `PRL_REMAP3_RST;
      state.protect   <= 1'b0;
      state.soft_rst  <= 1'b0;
      state.rdata     <= 8'h00;
      state.port3_log <= `PRL_NATURAL_PORT;
      state.port3_en  <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign reg_rdata_o     = state.rdata;
  assign port3_logical_o = state.port3_log;
  assign port3_enable_o  = state.port3_en;
  assign cfg_protect_o   = state.protect;
  assign soft_reset_o    = state.soft_rst;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_remap_after_reset: assert property (
    $fell(srst_i) |-> state.remap == 4'h3 && !cfg_protect_o)
    else $error("remap not 0x3 after reset");

  a_protect_sticky: assert property (
    cfg_protect_o |=> cfg_protect_o)
    else $error("protect bit cleared without reset");

  a_protect_blocks_wr: assert property (
    cfg_protect_o && wr_remap && !wr_status
      |=> state.remap == $past(state.remap))
    else $error("protected write changed remap");

  a_soft_rst_set: assert property (
    wr_status && reg_wdata_i[1] |=> soft_reset_o)
    else $error("soft reset request gave no pulse");

  a_soft_rst_pulse: assert property (
    soft_reset_o && !(wr_status && reg_wdata_i[1]) |=> !soft_reset_o)
    else $error("soft reset bit did not clear itself");

  a_soft_rst_keeps: assert property (
    cfg_protect_o && wr_status && reg_wdata_i[1]
      |=> soft_reset_o && cfg_protect_o)
    else $error("soft reset refused or lock lost");

  a_soft_rst_remap: assert property (
    wr_status && reg_wdata_i[1] |=> state.remap == 4'h3)
    else $error("soft reset left remap changed");

  a_reserved_code: assert property (
    wr_remap && !cfg_protect_o && reg_wdata_i[3:0] > 4'h3
      |=> state.remap == 4'h0)
    else $error("reserved code not stored as disabled");

  a_valid_code: assert property (
    wr_remap && !cfg_protect_o && reg_wdata_i[3:0] <= 4'h3
      |=> state.remap == $past(reg_wdata_i[3:0]))
    else $error("valid remap code not stored");

  a_natural_order: assert property (
    !remap_mode_enable_i |=> port3_logical_o == 2'h3 && port3_enable_o)
    else $error("port numbering changed with remap off");

  a_remap_output: assert property (
    remap_mode_enable_i && state.remap == 4'h0 |=> !port3_enable_o)
    else $error("disabled code left port enabled");

  a_unmapped_read: assert property (
    reg_rd_i && reg_addr_i != 8'hFC && reg_addr_i != 8'hFF
      |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  a_protect_set: assert property (
    wr_status && reg_wdata_i[0] |=> cfg_protect_o)
    else $error("protect bit not set by write");

  a_protect_idle: assert property (
    !cfg_protect_o && !(wr_status && reg_wdata_i[0])
      |=> !cfg_protect_o)
    else $error("protect bit set without a write");

  a_remap_hold: assert property (
    !wr_remap && !(wr_status && reg_wdata_i[1])
      |=> $stable(state.remap))
    else $error("remap changed without a write");

  a_code_in_range: assert property (
    state.remap <= 4'h3)
    else $error("reserved code held in remap");

  a_port_code: assert property (
    remap_mode_enable_i && state.remap >= 4'h1 && state.remap <= 4'h3
      |=> port3_enable_o && port3_logical_o == $past(state.remap[1:0]))
    else $error("mapped code gave wrong logical port");

  // ==========================================================
  // read path
  a_remap_read: assert property (
    reg_rd_i && reg_addr_i == 8'hFC
      |=> reg_rdata_o == {4'h0, $past(state.remap)})
    else $error("remap read data wrong");

  a_status_read: assert property (
    reg_rd_i && reg_addr_i == 8'hFF
      |=> reg_rdata_o == {6'h00, $past(soft_reset_o),
                          $past(cfg_protect_o)})
    else $error("status read data wrong");

  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data left standing");

  c_protect_set: cover property (wr_status && reg_wdata_i[0]);
  c_soft_rst_locked: cover property (cfg_protect_o && soft_reset_o);
  c_reserved_write: cover property (
    wr_remap && !cfg_protect_o && reg_wdata_i[3:0] > 4'h3);
  c_remap_log1: cover property (
    remap_mode_enable_i && state.remap == 4'h1 ##1 port3_logical_o == 2'h1);

endmodule : prl_top

// File: sim/prl_host_model.sv
/*
 * Host model: issues single-byte register writes and reads.
 * Assumes the byte strobe port of prl_top and a shared clock.
 */
module prl_host_model
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // ==========================================================
  // byte access, released lines show inverted values
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge mclk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge mclk_i);
    d      = rdata_i;
    rd_o   = 1'b0;
    addr_o = ~a;
  endtask : read
endmodule : prl_host_model

// File: sim/testbench.sv
/*
 * Self-checking bench for prl_top.
 * Assumes prl_defs.svh on the include path.
 */
`include "prl_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic       mclk;
  logic       srst;
  logic       remap_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [1:0] port3_logical;
  logic       port3_enable;
  logic       cfg_protect;
  logic       soft_reset;
  int         errors   = 0;
  int         n_checks = 0;
  int         cycles   = 0;

  prl_top u_prl_top (.mclk_i(mclk), .srst_i(srst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .remap_mode_enable_i(remap_en), .reg_rdata_o(rdata),
    .port3_logical_o(port3_logical), .port3_enable_o(port3_enable),
    .cfg_protect_o(cfg_protect), .soft_reset_o(soft_reset));

  prl_host_model u_prl_host_model (.mclk_i(mclk), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    u_prl_host_model.write(a, d);
  endtask : wr_b

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_prl_host_model.read(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic port_chk(input logic [1:0] l, input logic e);
    @(negedge mclk);
    chk({5'h00, port3_enable, port3_logical}, {5'h00, e, l});
  endtask : port_chk

  task automatic close_out;
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ==========================================================
  // scenarios
  task automatic t_reset_values;
    rd_chk(`PRL_ADDR_REMAP3, 8'h03);
    rd_chk(`PRL_ADDR_STATUS, 8'h00);
    port_chk(2'h3, 1'b1);
  endtask : t_reset_values

  task automatic t_codes;
    logic [3:0] c;
    logic [1:0] l;
    logic       e;
    remap_en = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      wr_b(`PRL_ADDR_REMAP3, {4'h0, c});
      rd_chk(`PRL_ADDR_REMAP3, (c > 4'h3) ? 8'h00 : {4'h0, c});
      l = (c > 4'h3) ? 2'h0 : c[1:0];
      e = c != 4'h0 && c < 4'h4;
      port_chk(l, e);
    end
  endtask : t_codes

  task automatic t_mode_off;
    wr_b(`PRL_ADDR_REMAP3, 8'h01);
    remap_en = 1'b0;
    port_chk(2'h3, 1'b1);
    remap_en = 1'b1;
    port_chk(2'h1, 1'b1);
    wr_b(8'hFE, 8'hFF);
    rd_chk(8'hFE, 8'h00);
    rd_chk(`PRL_ADDR_REMAP3, 8'h01);
  endtask : t_mode_off

  task automatic t_soft_reset;
    wr_b(`PRL_ADDR_STATUS, 8'h02);
    chk({7'h00, soft_reset}, 8'h01);
    @(negedge mclk);
    chk({7'h00, soft_reset}, 8'h00);
    rd_chk(`PRL_ADDR_REMAP3, 8'h03);
    rd_chk(`PRL_ADDR_STATUS, 8'h00);
  endtask : t_soft_reset

  task automatic t_protect;
    wr_b(`PRL_ADDR_STATUS, 8'h01);
    chk({7'h00, cfg_protect}, 8'h01);
    wr_b(`PRL_ADDR_REMAP3, 8'h02);
    rd_chk(`PRL_ADDR_REMAP3, 8'h03);
    wr_b(`PRL_ADDR_STATUS, 8'h00);
    rd_chk(`PRL_ADDR_STATUS, 8'h01);
    wr_b(`PRL_ADDR_STATUS, 8'h02);
    chk({6'h00, soft_reset, cfg_protect}, 8'h03);
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    chk({7'h00, cfg_protect}, 8'h00);
    rd_chk(`PRL_ADDR_REMAP3, 8'h03);
    wr_b(`PRL_ADDR_REMAP3, 8'h01);
    rd_chk(`PRL_ADDR_REMAP3, 8'h01);
  endtask : t_protect

  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      $display("BAD %0t run too long", $time);
      close_out();
    end
  end

  initial
  begin
    srst     = 1'b1;
    remap_en = 1'b0;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    t_reset_values();
    t_codes();
    t_mode_off();
    t_soft_reset();
    t_protect();
    close_out();
  end
endmodule : testbench
